/* src/dcc_top.sv */
// dual-pack charge controller: phase sequencing, gating outputs and register slave
//
// Overview of operation
// (RULE1) a falling edge on the pack A discharge command starts discharge to the lower limit.
// (RULE2) with the command held low, each new charge cycle starts with discharge.
// (RULE3) the negative delta voltage test runs only while its enable input is high.
// (RULE4) the two three-level mode inputs select time limit, hold-off and top-off.
// (RULE5) a temperature below cutoff ends fast or top-off charge for that pack only.
// (RULE6) each pack gate is high to pass charge current and low to block it.
// (RULE7) in regulation the gate follows the current sense comparator.
// (RULE8) with sense tied to ground the gate is high for the whole fast charge.
// (RULE9) discharge output stays high until the cell is below the lower limit, then qualification.
// (RULE10) the discharge command idles high, so a floating input does nothing.
// (RULE11) the discharge command edge overrides any phase in progress.
// (RULE12) each pack has a push-pull status output and an open-drain done output.
// (RULE13) a new cycle starts with discharge if the command is tied low, else qualification.
// (RULE14) with the test enabled, sample every 34 s and stop on a 12 mV drop below the peak.
// (RULE15) comparator flags are synchronised before any state decision.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module dcc_top #(
    parameter int unsigned SEC_CYCLES = dcc_pkg::SEC_CYCLES
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // board switches and straps
    input  wire logic        discharge_command_n,
    input  wire logic        neg_delta_v_enable,
    input  wire logic [1:0]  timer_mode_sel_1,
    input  wire logic [1:0]  timer_mode_sel_2,
    // per-pack comparator flags, bit 0 pack a, bit 1 pack b
    input  wire logic [1:0]  below_edv,
    input  wire logic [1:0]  above_mcv,
    input  wire logic [1:0]  below_temp_cutoff,
    input  wire logic [1:0]  above_cold_limit,
    input  wire logic [1:0]  current_over,
    input  wire logic [1:0]  current_sense_grounded,
    // per-pack cell voltage words
    input  wire logic [11:0] pack_voltage_a,
    input  wire logic [11:0] pack_voltage_b,
    // pack outputs
    output logic [1:0]       charge_current_gate,
    output logic             discharge_drive,
    output logic             charge_status_a,
    output logic             charge_status_b,
    output logic [1:0]       fast_charge_done_o,
    output logic [1:0]       fast_charge_done_oe
);
    localparam int unsigned NF = 14;

    // flag synchroniser, discharge_command_n idles high like its pad pull-up
    logic [NF-1:0] sync1_q;
    logic [NF-1:0] sync2_q;
    logic [NF-1:0] flag_rst;
    assign flag_rst = {1'b1, {(NF-1){1'b0}}}; // RULE10
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= flag_rst;
            sync2_q <= flag_rst;
        end else begin
            sync1_q <= {discharge_command_n, neg_delta_v_enable, below_edv, above_mcv,
                        below_temp_cutoff, above_cold_limit, current_over,
                        current_sense_grounded}; // RULE15
            sync2_q <= sync1_q; // RULE15
        end
    end

    logic       discharge_command_n_s;
    logic       neg_delta_v_enable_s;
    logic [1:0] edv_s;
    logic [1:0] mcv_s;
    logic [1:0] tcut_s;
    logic [1:0] cold_s;
    logic [1:0] iover_s;
    logic [1:0] gnd_s;
    assign {discharge_command_n_s, neg_delta_v_enable_s, edv_s, mcv_s, tcut_s, cold_s, iover_s, gnd_s} = sync2_q;

    // edge history for the command and the over-voltage flag
    logic       discharge_command_n_prev_q;
    logic [1:0] mcv_prev_q;
    logic       discharge_command_n_fall;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            discharge_command_n_prev_q <= 1'b1;
            mcv_prev_q  <= 2'b00;
        end else begin
            discharge_command_n_prev_q <= discharge_command_n_s;
            mcv_prev_q  <= mcv_s;
        end
    end
    assign discharge_command_n_fall = discharge_command_n_prev_q & ~discharge_command_n_s; // RULE1 RULE11

    // one second tick from a divider
    logic [31:0] div_q;
    logic        tick;
    assign tick = (div_q == SEC_CYCLES - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            div_q <= 32'h0000_0000;
        end else begin
            div_q <= div_q + 32'h0000_0001;
        end
    end

    // mode decode from the two three-level inputs
    logic [1:0]  tm1_lvl;
    logic [1:0]  tm2_lvl;
    logic [3:0]  mode_idx;
    logic [15:0] limit_s;
    logic [15:0] holdoff_s;
    logic        topoff_on;
    assign tm1_lvl   = (timer_mode_sel_1 > dcc_pkg::TRI_HIGH) ? dcc_pkg::TRI_FLOAT
                                                              : timer_mode_sel_1;
    assign tm2_lvl   = (timer_mode_sel_2 > dcc_pkg::TRI_HIGH) ? dcc_pkg::TRI_FLOAT
                                                              : timer_mode_sel_2;
    assign mode_idx  = 4'(tm2_lvl * dcc_pkg::TRI_LEVELS) + {2'b00, tm1_lvl}; // RULE4
    assign limit_s   = 16'({7'h00, dcc_pkg::FC_LIMIT_MIN[mode_idx]}
                           * dcc_pkg::SEC_PER_MIN); // RULE4
    assign holdoff_s = dcc_pkg::HOLDOFF_S[mode_idx]; // RULE4
    assign topoff_on = dcc_pkg::TOPOFF_EN[mode_idx]; // RULE4

    // control register, enable bit steers the phase machines
    logic [31:0] ctrl_q;
    logic        run;
    assign run = ctrl_q[dcc_pkg::CTRL_ENABLE];

    logic [11:0] volt [2];
    assign volt[0] = pack_voltage_a;
    assign volt[1] = pack_voltage_b;

    dcc_pkg::dcc_state_e st_q [2];
    logic [1:0] ndv_hit;
    logic [1:0] status_led;

    // per-pack phase machine and outputs
    for (genvar i = 0; i < 2; i++) begin : g_pack
        dcc_pkg::dcc_state_e st_d;
        logic [15:0] sec_q;
        logic [5:0]  samp_q;
        logic [11:0] peak_q;
        logic        samp_tick;
        logic        ho_done;
        logic        hot;
        logic        active;
        logic        dis_go;
        assign samp_tick  = tick && (samp_q == dcc_pkg::NDV_SAMPLE_S - 6'd1);
        assign ho_done    = (sec_q >= holdoff_s);
        assign hot        = tcut_s[i] | cold_s[i];
        assign dis_go     = (i == 0) && discharge_command_n_fall;
        assign ndv_hit[i] = samp_tick && neg_delta_v_enable_s && ho_done && (st_q[i] == dcc_pkg::ST_FAST)
                            && (peak_q > volt[i])
                            && (peak_q - volt[i] >= dcc_pkg::NDV_DROP_CODE); // RULE3 RULE14
        // top-off runs 4 s on in every 34 s window
        assign active     = (st_q[i] == dcc_pkg::ST_FAST)
                            || (st_q[i] == dcc_pkg::ST_TOPOFF
                                && samp_q < dcc_pkg::TOPOFF_ON_S);

        // next phase
        always_comb begin
            st_d = st_q[i];
            unique case (st_q[i])
                dcc_pkg::ST_INIT: begin
                    st_d = (i == 0 && !discharge_command_n_s) ? dcc_pkg::ST_DISCH
                                               : dcc_pkg::ST_PEND; // RULE2 RULE13
                end
                dcc_pkg::ST_PEND: begin
                    if (mcv_s[i]) begin
                        st_d = dcc_pkg::ST_ABSENT;
                    end else if (!hot && !edv_s[i]) begin
                        st_d = dcc_pkg::ST_FAST;
                    end
                end
                dcc_pkg::ST_DISCH: begin
                    if (edv_s[i]) begin
                        st_d = dcc_pkg::ST_PEND; // RULE9
                    end
                end
                dcc_pkg::ST_FAST: begin
                    // a hot or cold pack skips top-off so that no current follows
                    if (hot) begin
                        st_d = dcc_pkg::ST_DONE; // RULE5
                    end else if (ndv_hit[i] || (mcv_s[i] && ho_done) || sec_q >= limit_s) begin
                        st_d = topoff_on ? dcc_pkg::ST_TOPOFF : dcc_pkg::ST_DONE; // RULE4
                    end
                end
                dcc_pkg::ST_TOPOFF: begin
                    if (hot || mcv_s[i] || sec_q >= limit_s) begin // RULE5
                        st_d = dcc_pkg::ST_DONE;
                    end
                end
                dcc_pkg::ST_DONE: begin
                    if (mcv_s[i]) begin
                        st_d = dcc_pkg::ST_ABSENT;
                    end
                end
                dcc_pkg::ST_ABSENT: begin
                    if (mcv_prev_q[i] && !mcv_s[i]) begin
                        st_d = dcc_pkg::ST_INIT;
                    end
                end
                default: st_d = dcc_pkg::ST_INIT;
            endcase
            if (dis_go) begin
                st_d = dcc_pkg::ST_DISCH; // RULE1 RULE11
            end
            if (!run) begin
                st_d = dcc_pkg::ST_INIT;
            end
        end

        // phase register
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                st_q[i] <= dcc_pkg::ST_INIT;
            end else begin
                st_q[i] <= st_d;
            end
        end

        // phase timers restart on every phase change
        always_ff @(posedge aclk) begin
            if (!aresetn || st_d != st_q[i]) begin
                sec_q  <= 16'h0000;
                samp_q <= 6'h00;
            end else if (tick) begin
                sec_q  <= (sec_q == 16'hffff) ? sec_q : sec_q + 16'h0001;
                samp_q <= samp_tick ? 6'h00 : samp_q + 6'h01;
            end
        end

        // running peak of voltage samples during fast charge
        always_ff @(posedge aclk) begin
            if (!aresetn || st_q[i] != dcc_pkg::ST_FAST) begin
                peak_q <= 12'h000;
            end else if (samp_tick && volt[i] > peak_q) begin
                peak_q <= volt[i]; // RULE14
            end
        end

        // registered pack outputs
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                charge_current_gate[i] <= 1'b0;
                fast_charge_done_oe[i] <= 1'b0;
                fast_charge_done_o[i]  <= 1'b0;
                status_led[i]          <= 1'b1;
            end else begin
                charge_current_gate[i] <= active && (gnd_s[i] || !iover_s[i]); // RULE6 RULE7 RULE8
                fast_charge_done_oe[i] <= (st_q[i] == dcc_pkg::ST_DONE)
                                          || (st_q[i] == dcc_pkg::ST_TOPOFF); // RULE12
                fast_charge_done_o[i]  <= 1'b0;
                status_led[i]          <= !(active && !mcv_s[i]); // RULE12
            end
        end

        // checks on each pack
        property p_gate_idle;
            @(posedge aclk) disable iff (!aresetn)
            (st_q[i] inside {dcc_pkg::ST_PEND, dcc_pkg::ST_DONE, dcc_pkg::ST_DISCH})
            |=> !charge_current_gate[i];
        endproperty
        a_gate_idle: assert property (p_gate_idle) else $error("gate high while idle"); // RULE6
        property p_gate_reg;
            @(posedge aclk) disable iff (!aresetn)
            (st_q[i] == dcc_pkg::ST_FAST && !gnd_s[i])
            |=> (charge_current_gate[i] == !$past(iover_s[i]));
        endproperty
        a_gate_reg: assert property (p_gate_reg) else $error("gate ignores sense"); // RULE7
        property p_gate_gnd;
            @(posedge aclk) disable iff (!aresetn)
            (st_q[i] == dcc_pkg::ST_FAST && gnd_s[i]) |=> charge_current_gate[i];
        endproperty
        a_gate_gnd: assert property (p_gate_gnd) else $error("gated mode gate low"); // RULE8
        property p_temp_cut;
            @(posedge aclk) disable iff (!aresetn)
            (st_q[i] inside {dcc_pkg::ST_FAST, dcc_pkg::ST_TOPOFF}) && tcut_s[i] && !dis_go
            |=> !(st_q[i] inside {dcc_pkg::ST_FAST, dcc_pkg::ST_TOPOFF}) ##1
                !charge_current_gate[i];
        endproperty
        a_temp_cut: assert property (p_temp_cut) else $error("hot pack still charging"); // RULE5
        property p_ndv_gate;
            @(posedge aclk) disable iff (!aresetn)
            ndv_hit[i] && run && !dis_go
            |=> st_q[i] inside {dcc_pkg::ST_TOPOFF, dcc_pkg::ST_DONE};
        endproperty
        a_ndv_gate: assert property (p_ndv_gate) else $error("drop did not end charge"); // RULE14
        property p_done_flag;
            @(posedge aclk) disable iff (!aresetn)
            st_q[i] == dcc_pkg::ST_DONE |=> fast_charge_done_oe[i];
        endproperty
        a_done_flag: assert property (p_done_flag) else $error("done output idle"); // RULE12
    end

    // pack a discharge drive and status pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            discharge_drive <= 1'b0;
            charge_status_a <= 1'b1;
            charge_status_b <= 1'b1;
        end else begin
            discharge_drive <= (st_q[0] == dcc_pkg::ST_DISCH); // RULE9
            charge_status_a <= status_led[0];
            charge_status_b <= status_led[1];
        end
    end

    property p_dis_cmd;
        @(posedge aclk) disable iff (!aresetn)
        discharge_command_n_fall && run |=> (st_q[0] == dcc_pkg::ST_DISCH) ##1 discharge_drive;
    endproperty
    a_dis_cmd: assert property (p_dis_cmd) else $error("command edge ignored"); // RULE11
    property p_dis_end;
        @(posedge aclk) disable iff (!aresetn)
        st_q[0] == dcc_pkg::ST_DISCH && edv_s[0] && !discharge_command_n_fall && run
        |=> st_q[0] == dcc_pkg::ST_PEND ##1 !discharge_drive;
    endproperty
    a_dis_end: assert property (p_dis_end) else $error("discharge not ended"); // RULE9
    property p_auto_dis;
        @(posedge aclk) disable iff (!aresetn)
        st_q[0] == dcc_pkg::ST_INIT && !discharge_command_n_s && run |=> st_q[0] == dcc_pkg::ST_DISCH;
    endproperty
    a_auto_dis: assert property (p_auto_dis) else $error("no auto discharge"); // RULE2

    // axi4-lite write channel, address and data taken in either order
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        aw_full_q;
    logic        w_full_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= dcc_pkg::RESP_OKAY;
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            awaddr_q      <= 12'h000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            ctrl_q        <= dcc_pkg::CTRL_RESET;
        end else begin
            if (s_axi_awready && s_axi_awvalid) begin
                awaddr_q      <= s_axi_awaddr;
                aw_full_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end else if (!aw_full_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                w_full_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end else if (!w_full_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (aw_full_q && w_full_q && !s_axi_bvalid) begin
                aw_full_q    <= 1'b0;
                w_full_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_q[11:2] == dcc_pkg::REG_CTRL[11:2]) begin
                    s_axi_bresp <= dcc_pkg::RESP_OKAY;
                    if (wstrb_q[0]) begin
                        ctrl_q[dcc_pkg::CTRL_ENABLE] <= wdata_q[dcc_pkg::CTRL_ENABLE];
                    end
                end else if (awaddr_q[11:2] == dcc_pkg::REG_STATUS[11:2]) begin
                    s_axi_bresp <= dcc_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= dcc_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // axi4-lite read channel
    logic [31:0] status_word;
    assign status_word = {20'h0_0000, fast_charge_done_oe, discharge_drive, status_led[1],
                          1'b0, 3'(st_q[1]), 1'b0, 3'(st_q[0])};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= dcc_pkg::RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= dcc_pkg::RESP_OKAY;
            if (s_axi_araddr[11:2] == dcc_pkg::REG_CTRL[11:2]) begin
                s_axi_rdata <= ctrl_q;
            end else if (s_axi_araddr[11:2] == dcc_pkg::REG_STATUS[11:2]) begin
                s_axi_rdata <= status_word;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= dcc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule

/* src/dcc_pkg.sv */
// constants, tables and types shared by the dual-pack charge controller
package dcc_pkg;
    // clock and time base
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned SEC_TICK_MS   = 1000;
    localparam int unsigned SEC_CYCLES    = CLK_HZ / 1000 * SEC_TICK_MS;
    localparam logic [5:0]  NDV_SAMPLE_S  = 6'd34;
    localparam logic [5:0]  TOPOFF_ON_S   = 6'd4;
    localparam logic [5:0]  TOPOFF_OFF_S  = 6'd30;
    localparam logic [15:0] SEC_PER_MIN   = 16'h003c;
    // voltage word scale and drop limit
    localparam int unsigned VOLT_LSB_UV   = 1000;
    localparam int unsigned NDV_DROP_MV   = 12;
    localparam logic [11:0] NDV_DROP_CODE = 12'(NDV_DROP_MV * 1000 / VOLT_LSB_UV);
    // three-level timer mode input codes
    localparam logic [1:0]  TRI_LOW       = 2'h0;
    localparam logic [1:0]  TRI_FLOAT     = 2'h1;
    localparam logic [1:0]  TRI_HIGH      = 2'h2;
    localparam logic [3:0]  TRI_LEVELS    = 4'h3;
    // mode table, index = sel_2 * 3 + sel_1
    localparam logic [8:0]  FC_LIMIT_MIN [0:8] = '{
        9'd360, 9'd180, 9'd90, 9'd45, 9'd23, 9'd180, 9'd90, 9'd45, 9'd23};
    localparam logic [15:0] HOLDOFF_S    [0:8] = '{
        16'd137, 16'd820, 16'd410, 16'd200, 16'd100, 16'd820, 16'd410, 16'd200, 16'd100};
    localparam logic [8:0]  TOPOFF_EN    = 9'h1e0;
    // register map
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_STATUS    = 12'h004;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
    localparam int unsigned CTRL_ENABLE   = 0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    // per-pack charge phases
    typedef enum logic [2:0] {
        ST_INIT, ST_PEND, ST_DISCH, ST_FAST, ST_TOPOFF, ST_DONE, ST_ABSENT
    } dcc_state_e;
endpackage

/* tb/dcc_pack_model.sv */
// battery pack model: pack a drains to the lower limit while its discharge drive is on
`timescale 1ns/1ps
module dcc_pack_model #(
    parameter int unsigned DIS_CYC = 20
) (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // discharge transistor in, lower limit flags out
    input  wire logic       discharge_drive,
    output logic      [1:0] below_edv
);
    int unsigned cnt_q;

    // discharge time, cell recovers as soon as the drive stops
    always_ff @(posedge aclk) begin
        if (!aresetn || !discharge_drive) begin
            cnt_q <= 0;
        end else if (cnt_q < DIS_CYC) begin
            cnt_q <= cnt_q + 1;
        end
    end

    // pack b stays above the lower limit
    assign below_edv = {1'b0, discharge_drive && (cnt_q >= DIS_CYC)};
endmodule

/* tb/test_discharge_charge_control.sv */
// self-checking bench for the dual-pack charge controller
`timescale 1ns/1ps
module test_discharge_charge_control;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd;
    logic [3:0]  wstrb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid, dis, st_a, st_b;
    logic [1:0]  bresp, rresp, rsp, end_of_discharge_threshold, gate, done_o, done_oe;
    logic        cmd_n = 1'b1, ndv_en = 1'b0;
    logic [1:0]  tm1 = 2'h0, tm2 = 2'h0, hot = 2'h0, cold = 2'h0, max_cell_voltage_threshold = 2'h0;
    logic [1:0]  over = 2'h0, gnd = 2'h3;
    logic [11:0] va = 12'h5dc, vb = 12'h5dc;
    int          n_errors = 0, checks_done = 0;

    // design with a short one second tick
    dcc_top #(.SEC_CYCLES(20)) dcc_top_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .discharge_command_n(cmd_n), .neg_delta_v_enable(ndv_en),
        .timer_mode_sel_1(tm1), .timer_mode_sel_2(tm2),
        .below_edv(end_of_discharge_threshold), .above_mcv(max_cell_voltage_threshold), .below_temp_cutoff(hot),
        .above_cold_limit(cold), .current_over(over), .current_sense_grounded(gnd),
        .pack_voltage_a(va), .pack_voltage_b(vb),
        .charge_current_gate(gate), .discharge_drive(dis),
        .charge_status_a(st_a), .charge_status_b(st_b),
        .fast_charge_done_o(done_o), .fast_charge_done_oe(done_oe)
    );

    // far side packs
    dcc_pack_model dcc_pack_model_inst (
        .aclk(aclk), .aresetn(aresetn), .discharge_drive(dis), .below_edv(end_of_discharge_threshold)
    );

    // 100 mhz clock
    always #5 aclk = ~aclk;

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // write: address and data offered together, each released when taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    // read: address held until taken, data taken with rvalid
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // phase codes of both packs from the status register
    task automatic st_chk(input logic [6:0] exp);
        axi_rd(dcc_pkg::REG_STATUS, rd, rsp);
        chk(32'(rd[6:0]), 32'(exp));
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // test sequence
    initial begin
        wait_cyc(4);
        aresetn <= 1'b1;
        wait_cyc(20);
        axi_rd(dcc_pkg::REG_CTRL, rd, rsp);
        chk(rd, dcc_pkg::CTRL_RESET);
        axi_rd(12'h010, rd, rsp);
        chk(rd, 32'h0000_0000);
        chk(32'(rsp), 32'(dcc_pkg::RESP_SLVERR));
        axi_wr(dcc_pkg::REG_STATUS, 32'h0000_0000, rsp);
        chk(32'(rsp), 32'(dcc_pkg::RESP_OKAY));
        $display("test registers done");
        st_chk(7'h33);
        chk(32'({gate, st_a, dis}), 32'h0000_000c);
        hot <= 2'b10;
        wait_cyc(10);
        chk(32'({gate, done_oe}), 32'h0000_0006);
        chk(32'({st_b, done_o}), 32'h0000_0004);
        st_chk(7'h53);
        $display("test cutoff done");
        cmd_n <= 1'b0;
        wait_cyc(2);
        cmd_n <= 1'b1;
        wait_cyc(6);
        chk(32'({gate[0], dis}), 32'h0000_0001);
        st_chk(7'h52);
        wait_cyc(60);
        chk(32'({gate[0], dis}), 32'h0000_0002);
        st_chk(7'h53);
        $display("test discharge done");
        gnd <= 2'b00;
        over <= 2'b01;
        wait_cyc(8);
        chk(32'(gate[0]), 32'h0000_0000);
        over <= 2'b00;
        wait_cyc(8);
        chk(32'(gate[0]), 32'h0000_0001);
        $display("test regulation done");
        hot <= 2'b00;
        axi_wr(dcc_pkg::REG_CTRL, 32'h0000_0000, rsp);
        cmd_n <= 1'b0;
        wait_cyc(5);
        st_chk(7'h00);
        chk(32'(gate), 32'h0000_0000);
        axi_wr(dcc_pkg::REG_CTRL, 32'h0000_0001, rsp);
        wait_cyc(6);
        chk(32'(dis), 32'h0000_0001);
        wait_cyc(60);
        st_chk(7'h33);
        $display("test auto discharge done");
        // top-off on, 100 s hold-off; peak taken before the drop
        tm1 <= dcc_pkg::TRI_HIGH;
        tm2 <= dcc_pkg::TRI_HIGH;
        wait_cyc(2100);
        va <= 12'h5bc;
        wait_cyc(700);
        st_chk(7'h33);
        ndv_en <= 1'b1;
        wait_cyc(700);
        st_chk(7'h34);
        chk(32'(done_oe), 32'h0000_0001);
        $display("test voltage drop done");
        wrap_up();
    end

    // hang guard
    initial begin
        wait_cyc(8000);
        n_errors++;
        wrap_up();
    end
endmodule
